// ===== logic/rx_filter_pkg.sv
// package: register map, field layout and mode codes of the receive filter configuration block
// Functional notes
// [R1] seven-bit buffer size at bits 10..4, one size for all descriptors, 16-byte units
// [R2] all-ones buffer size field means 2032 bytes per descriptor
// [R3] software changes size and filter settings only while receiver enable is 0
// [R4] bit 15 turns hash table filtering on or off
// [R5] bit 14 turns wake-packet filtering on or off
// [R6] bit 12 inverts what counts as checksum success
// [R7] mode 0000 disables pattern match, result always unsuccessful
// [R8] mode 0001 matches when invert bit xor checksum-equal is true
// [R9] modes 0010/0011 also need destination equal to station address
// [R10] modes 0100/0101 also need a unicast destination address
// [R11] modes 0110/0111 also need the broadcast destination address
// [R12] mode 1000 also needs a hash hit, computed even with hash filtering off
// [R13] mode 1001 also needs a wake packet, detected even with wake filtering off
// [R14] unimplemented register bits read zero, implemented fields reset to zero
// [R15] mode codes above 1001 never report a pattern match
package rx_filter_pkg;
	localparam logic [3:0]  ADDR_CTRL_ONE     = 4'h0;
	localparam logic [3:0]  ADDR_BUF_SIZE     = 4'h4;
	localparam logic [3:0]  ADDR_FILTER_CFG   = 4'h8;
	localparam logic [3:0]  ADDR_STATUS       = 4'hc;
	localparam int          RECEIVER_ENABLE_BIT          = 8;
	localparam int          BUFSZ_LSB         = 4;
	localparam int          BUFSZ_W           = 7;
	localparam int          HT_EN_BIT         = 15;
	localparam int          WP_EN_BIT         = 14;
	localparam int          INV_BIT           = 12;
	localparam int          MODE_LSB          = 8;
	localparam int          MODE_W            = 4;
	localparam int          UNIT_BYTES_LOG2   = 4;
	localparam logic [15:0] FILTER_CFG_MASK   = 16'hdfff;
	localparam logic [6:0]  BUFSZ_RESET       = 7'h00;
	localparam logic [15:0] FILTER_RESET      = 16'h0000;
	localparam logic [3:0]  PM_OFF            = 4'h0;
	localparam logic [3:0]  PM_CSUM           = 4'h1;
	localparam logic [3:0]  PM_STATION_A      = 4'h2;
	localparam logic [3:0]  PM_STATION_B      = 4'h3;
	localparam logic [3:0]  PM_UNICAST_A      = 4'h4;
	localparam logic [3:0]  PM_UNICAST_B      = 4'h5;
	localparam logic [3:0]  PM_BROADCAST_A    = 4'h6;
	localparam logic [3:0]  PM_BROADCAST_B    = 4'h7;
	localparam logic [3:0]  PM_HASH           = 4'h8;
	localparam logic [3:0]  PM_WAKE           = 4'h9;
endpackage : rx_filter_pkg

// ===== logic/pattern_match_eval.sv
// pattern-match decision from mode, inversion bit and per-frame match conditions
`timescale 1ns/1ps
`default_nettype none
module pattern_match_eval
(
	input  wire logic [3:0] i_mode,
	input  wire logic       i_invert,
	input  wire logic       i_csum_equal,
	input  wire logic       i_da_station,
	input  wire logic       i_da_unicast,
	input  wire logic       i_da_broadcast,
	input  wire logic       i_hash_hit,
	input  wire logic       i_wake_packet,
	output logic            o_match
);
	import rx_filter_pkg::*;

	logic csum_ok;

	// checksum success is the xor of inversion and equality
	assign csum_ok = i_invert ^ i_csum_equal; // [R6]

	// per-mode qualification of the checksum result
	always_comb
	begin
		case (i_mode)
			PM_OFF:                        o_match = 1'b0;                       // [R7]
			PM_CSUM:                       o_match = csum_ok;                    // [R8]
			PM_STATION_A, PM_STATION_B:    o_match = csum_ok & i_da_station;     // [R9]
			PM_UNICAST_A, PM_UNICAST_B:    o_match = csum_ok & i_da_unicast;     // [R10]
			PM_BROADCAST_A, PM_BROADCAST_B: o_match = csum_ok & i_da_broadcast;  // [R11]
			PM_HASH:                       o_match = csum_ok & i_hash_hit;       // [R12]
			PM_WAKE:                       o_match = csum_ok & i_wake_packet;    // [R13]
			default:                       o_match = 1'b0;                       // [R15]
		endcase
	end
endmodule : pattern_match_eval
`default_nettype wire

// ===== logic/eth_rx_filter_cfg.sv
// receive buffer size and receive filter configuration registers with per-frame filter decisions
`timescale 1ns/1ps
`default_nettype none
module eth_rx_filter_cfg
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_frame_done,
	input  wire logic        i_csum_equal,
	input  wire logic        i_da_station,
	input  wire logic        i_da_unicast,
	input  wire logic        i_da_broadcast,
	input  wire logic        i_hash_hit,
	input  wire logic        i_wake_packet,
	output logic             o_receiver_enable,
	output logic [rx_filter_pkg::BUFSZ_W-1:0] o_rx_buffer_size_units,
	output logic [11:0]      o_rx_buffer_bytes,
	output logic             o_hash_filter_enable,
	output logic             o_wake_packet_filter_enable,
	output logic             o_result_valid,
	output logic             o_pattern_match,
	output logic             o_hash_accept,
	output logic             o_wake_accept
);
	import rx_filter_pkg::*;

	typedef struct packed {
		logic                receiver_enable;
		logic [BUFSZ_W-1:0]  bufsz;
		logic [15:0]         fcfg;
		logic [31:0]         rdata;
		logic                vld;
		logic                pm;
		logic                ht;
		logic                wp;
		logic                pm_last;
		logic                blocked;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   pm_now;
	logic   cfg_write;

	// combinational pattern-match decision for the frame now ending
	pattern_match_eval u_eval (
		.i_mode         (s_q.fcfg[MODE_LSB +: MODE_W]),
		.i_invert       (s_q.fcfg[INV_BIT]),
		.i_csum_equal   (i_csum_equal),
		.i_da_station   (i_da_station),
		.i_da_unicast   (i_da_unicast),
		.i_da_broadcast (i_da_broadcast),
		.i_hash_hit     (i_hash_hit),
		.i_wake_packet  (i_wake_packet),
		.o_match        (pm_now)
	);

	// any write to size or filter setup, whether the receiver is on or off
	assign cfg_write = i_wr && (i_addr == ADDR_BUF_SIZE || i_addr == ADDR_FILTER_CFG);

	// next-state logic: register writes, read mux, per-frame results
	always_comb
	begin
		s_d = s_q;
		s_d.vld = 1'b0;
		s_d.rdata = 32'h0000_0000;
		if (i_wr && i_addr == ADDR_CTRL_ONE)
			s_d.receiver_enable = i_wdata[RECEIVER_ENABLE_BIT];
		if (i_wr && i_addr == ADDR_BUF_SIZE && !s_q.receiver_enable)
			s_d.bufsz = i_wdata[BUFSZ_LSB +: BUFSZ_W]; // [R1]
		if (i_wr && i_addr == ADDR_FILTER_CFG && !s_q.receiver_enable)
			s_d.fcfg = i_wdata[15:0] & FILTER_CFG_MASK; // [R14]
		if (i_rd)
		begin
			case (i_addr)
				ADDR_CTRL_ONE:   s_d.rdata = {23'h000000, s_q.receiver_enable, 8'h00};
				ADDR_BUF_SIZE:   s_d.rdata = {21'h000000, s_q.bufsz, 4'h0}; // [R14]
				ADDR_FILTER_CFG: s_d.rdata = {16'h0000, s_q.fcfg}; // [R14]
				ADDR_STATUS:     s_d.rdata = {30'h00000000, s_q.blocked, s_q.pm_last};
				default:         s_d.rdata = 32'h0000_0000;
			endcase
			if (i_addr == ADDR_STATUS)
				s_d.blocked = 1'b0;
		end
		// a refused write in the same cycle as the status read still sticks
		if (cfg_write && s_q.receiver_enable)
			s_d.blocked = 1'b1; // [R3]
		if (i_frame_done && s_q.receiver_enable)
		begin
			s_d.vld = 1'b1;
			s_d.pm = pm_now;
			s_d.pm_last = pm_now;
			s_d.ht = s_q.fcfg[HT_EN_BIT] & i_hash_hit; // [R4]
			s_d.wp = s_q.fcfg[WP_EN_BIT] & i_wake_packet; // [R5]
		end
		else
		begin
			s_d.pm = 1'b0;
			s_d.ht = 1'b0;
			s_d.wp = 1'b0;
		end
	end

	// state register with synchronous reset to all zero
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			s_q <= '0;
			s_q.bufsz <= BUFSZ_RESET; // [R14]
			s_q.fcfg <= FILTER_RESET;
		end
		else
			s_q <= s_d;
	end

	// outputs taken straight from the state register
	assign o_rdata                     = s_q.rdata;
	assign o_receiver_enable           = s_q.receiver_enable;
	assign o_rx_buffer_size_units      = s_q.bufsz;
	// bytes per descriptor; all-ones gives 2032
	assign o_rx_buffer_bytes           = {1'b0, s_q.bufsz, 4'h0}; // [R2]
	assign o_hash_filter_enable        = s_q.fcfg[HT_EN_BIT]; // [R4]
	assign o_wake_packet_filter_enable = s_q.fcfg[WP_EN_BIT]; // [R5]
	assign o_result_valid              = s_q.vld;
	assign o_pattern_match             = s_q.pm;
	assign o_hash_accept               = s_q.ht;
	assign o_wake_accept               = s_q.wp;
endmodule : eth_rx_filter_cfg
`default_nettype wire

// ===== tb/rx_filter_sva.sv
// port-level assertions for the receive filter configuration block
`timescale 1ns/1ps
`default_nettype none
module rx_filter_sva
(
	input wire logic                 i_mclk,
	input wire logic                 i_rst,
	input wire logic                 i_frame_done,
	input wire logic                 i_hash_hit,
	input wire logic                 i_wake_packet,
	input wire logic                 o_receiver_enable,
	input wire logic [rx_filter_pkg::BUFSZ_W-1:0] o_rx_buffer_size_units,
	input wire logic [11:0]          o_rx_buffer_bytes,
	input wire logic                 o_hash_filter_enable,
	input wire logic                 o_wake_packet_filter_enable,
	input wire logic                 o_result_valid,
	input wire logic                 o_pattern_match,
	input wire logic                 o_hash_accept,
	input wire logic                 o_wake_accept
);
	import rx_filter_pkg::*;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// a frame end taken while the receiver runs
	sequence s_frame;
		i_frame_done && o_receiver_enable;
	endsequence
	AST_BYTES: assert property (o_rx_buffer_bytes == {1'b0, o_rx_buffer_size_units, 4'h0}) else $error("bytes");
	AST_HASH: assert property (s_frame |=> o_result_valid && o_hash_accept == $past(i_hash_hit && o_hash_filter_enable))
		else $error("hash");
	AST_WAKE: assert property (s_frame |=> o_wake_accept == $past(i_wake_packet && o_wake_packet_filter_enable))
		else $error("wake");
	AST_NOACC: assert property (!o_result_valid |-> !o_pattern_match && !o_hash_accept && !o_wake_accept)
		else $error("idle");
	AST_IDLE: assert property (!o_receiver_enable |=> !o_result_valid) else $error("off");
	AST_HOLD_SIZE: assert property (o_receiver_enable |=> $stable(o_rx_buffer_size_units)) else $error("size");
	AST_HOLD_FILT: assert property (o_receiver_enable |=> $stable({o_hash_filter_enable, o_wake_packet_filter_enable}))
		else $error("filt");
	AST_RESET: assert property (disable iff (1'b0) i_rst |=> !o_receiver_enable && o_rx_buffer_bytes == 12'h000
		&& !o_hash_filter_enable && !o_wake_packet_filter_enable) else $error("reset");
endmodule : rx_filter_sva
`default_nettype wire

// ===== tb/phy_frame_model.sv
// frame-end model of the receive side with per-frame match conditions
`timescale 1ns/1ps
`default_nettype none
module phy_frame_model
(
	input  wire logic       i_mclk,
	output var  logic       o_done,
	output var  logic [5:0] o_cond
);
	initial {o_done, o_cond} = 7'h00;
	// conditions hold only with the pulse, then flip so stale values never look valid
	task automatic send(input logic [5:0] c);
		@(posedge i_mclk);
		o_cond <= c;
		o_done <= 1'b1;
		@(posedge i_mclk);
		o_done <= 1'b0;
		o_cond <= ~c;
	endtask : send
endmodule : phy_frame_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the receive filter configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rx_filter_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done, rv, pm, ha, wa, ren, hen, wen;
	logic [3:0] addr = 4'h0;
	logic [5:0] cond;
	logic [6:0] units;
	logic [11:0] bytes;
	logic [31:0] wdata = 32'h0, rdata, v;
	int bad_count = 0, n_checks = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	phy_frame_model u_phy (.i_mclk(mclk), .o_done(done), .o_cond(cond));
	eth_rx_filter_cfg u_dut (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_frame_done(done), .i_csum_equal(cond[5]), .i_da_station(cond[4]), .i_da_unicast(cond[3]),
		.i_da_broadcast(cond[2]), .i_hash_hit(cond[1]), .i_wake_packet(cond[0]), .o_receiver_enable(ren),
		.o_rx_buffer_size_units(units), .o_rx_buffer_bytes(bytes), .o_hash_filter_enable(hen),
		.o_wake_packet_filter_enable(wen), .o_result_valid(rv), .o_pattern_match(pm), .o_hash_accept(ha),
		.o_wake_accept(wa));
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : cmp
	task automatic wrt(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wrt
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		{addr, rd} <= {a, 1'b1};
		@(posedge mclk);
		rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
	endtask : rdc
	function automatic logic exp_pm(input logic [3:0] m, input logic inv, input logic [5:0] c);
		case (m)
			4'h1: return inv ^ c[5];
			4'h2, 4'h3: return (inv ^ c[5]) & c[4];
			4'h4, 4'h5: return (inv ^ c[5]) & c[3];
			4'h6, 4'h7: return (inv ^ c[5]) & c[2];
			4'h8: return (inv ^ c[5]) & c[1];
			4'h9: return (inv ^ c[5]) & c[0];
			default: return 1'b0;
		endcase
	endfunction : exp_pm
	// register widths, the all-ones buffer size and masks
	task automatic t_regs;
		rdc(ADDR_FILTER_CFG, 32'h0);
		rdc(4'h2, 32'h0);
		wrt(ADDR_BUF_SIZE, 32'hffffffff);
		rdc(ADDR_BUF_SIZE, 32'h7f0);
		cmp("units", 32'h7f, units);
		cmp("bytes", 32'h7f0, bytes);
		wrt(ADDR_FILTER_CFG, 32'hffffffff);
		rdc(ADDR_FILTER_CFG, 32'hdfff);
		cmp("enables", 32'h3, {hen, wen});
	endtask : t_regs
	// every mode and inversion against a set of frame conditions
	task automatic t_modes;
		logic [5:0] pat [4] = '{6'h3f, 6'h1f, 6'h2a, 6'h15};
		for (int i = 0; i < 32; i++)
		begin
			wrt(ADDR_FILTER_CFG, {16'h0, i[1], i[0], 1'b0, i[4], i[3:0], 8'h00});
			wrt(ADDR_CTRL_ONE, 32'h100);
			foreach (pat[k])
			begin
				u_phy.send(pat[k]);
				#1 cmp("match", exp_pm(i[3:0], i[4], pat[k]), pm);
				cmp("accepts", {1'b1, i[1] & pat[k][1], i[0] & pat[k][0]}, {rv, ha, wa});
			end
			wrt(ADDR_CTRL_ONE, 32'h0);
		end
	endtask : t_modes
	// writes while receiving are refused and flagged; frames ignored when off
	task automatic t_refuse;
		wrt(ADDR_BUF_SIZE, 32'h10);
		wrt(ADDR_FILTER_CFG, 32'h100);
		wrt(ADDR_CTRL_ONE, 32'h100);
		// checksum-only mode with an equal checksum leaves a match in the status word
		u_phy.send(6'h20);
		#1 cmp("match", 32'h1, pm);
		wrt(ADDR_BUF_SIZE, 32'h50);
		wrt(ADDR_FILTER_CFG, 32'hffff);
		rdc(ADDR_BUF_SIZE, 32'h10);
		cmp("bytes", 32'h10, bytes);
		rdc(ADDR_FILTER_CFG, 32'h100);
		rdc(ADDR_STATUS, 32'h3);
		rdc(ADDR_STATUS, 32'h1);
		wrt(ADDR_CTRL_ONE, 32'h0);
		u_phy.send(6'h3f);
		#1 cmp("valid", 32'h0, rv);
	endtask : t_refuse
	// reset in mid-run while receiving brings every field back to zero
	task automatic t_reset;
		wrt(ADDR_FILTER_CFG, 32'hc000);
		wrt(ADDR_CTRL_ONE, 32'h100);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rdc(ADDR_FILTER_CFG, 32'h0);
		rdc(ADDR_BUF_SIZE, 32'h0);
		cmp("enables", 32'h0, {ren, hen, wen});
	endtask : t_reset
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// cycle ceiling: a hang counts as a mismatch and goes to the report
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_refuse();
		t_reset();
		summarize();
	end
endmodule : tb_top
bind eth_rx_filter_cfg rx_filter_sva u_sva (.i_mclk, .i_rst, .i_frame_done, .i_hash_hit, .i_wake_packet, .o_receiver_enable,
	.o_rx_buffer_size_units, .o_rx_buffer_bytes, .o_hash_filter_enable, .o_wake_packet_filter_enable, .o_result_valid,
	.o_pattern_match, .o_hash_accept, .o_wake_accept);
`default_nettype wire
